/* File: design/srx_pkg.sv */
package srx_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_CTRL1  = 8'h08;
    localparam logic [7:0] ADDR_CTRL2  = 8'h0C;
    localparam logic [7:0] ADDR_BAUD   = 8'h10;
    localparam logic [7:0] ADDR_IRQST  = 8'h14;
    localparam logic [7:0] ADDR_IRQMSK = 8'h18;
    // status bit positions
    localparam int ST_PARITY  = 0;
    localparam int ST_FRAMING = 1;
    localparam int ST_NOISE   = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_IDLE    = 4;
    localparam int ST_RXFULL  = 5;
    localparam int ST_TXEMPTY = 7;
    // ctrl1 bits
    localparam int C1_PARIRQ  = 1;
    localparam int C1_PAREN   = 2;
    localparam int C1_PARODD  = 3;
    localparam int C1_WORD9   = 4;
    localparam int C1_NINTH   = 7;
    // ctrl2 bits
    localparam int C2_BREAK   = 0;
    localparam int C2_RXEN    = 2;
    localparam int C2_TXEN    = 3;
    localparam int C2_IDLEIRQ = 4;
    localparam int C2_RXIRQ   = 5;
    localparam int C2_GMASK   = 7;
    // reset values, oversampling factor and bus response codes
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h0010;
    localparam int OVS = 16;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } srx_rx_e;

    typedef enum logic [3:0] {
        TX_OFF   = 4'b0001,
        TX_IDLEF = 4'b0010,
        TX_FRAME = 4'b0100,
        TX_MARK  = 4'b1000
    } srx_tx_e;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic noise;
        logic parity;
        logic idle;
    } srx_err_s;
endpackage

/* File: design/srx_uart.sv */
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
// Behaviour
// - after break ends, transmitter sends one mark bit before next frame
// - enabling transmitter sends one idle frame before first data frame
// - toggling transmit enable mid-frame sends idle frame after current word
// - toggling transmit enable discards transmit holding buffer content
// - receiver takes 8 or 9 bit words; ninth bit stored in ctrl1
// - serial data shifts in lsb first into shift then holding buffer
// - receive enable starts start-bit search
// - completed character moves to holding buffer and sets receive-full
// - receive irq when full, rx irq enabled and global mask clear
// - receive-full clears by status access then data read
// - break character is treated as framing error
// - idle line of 10 bit times sets idle flag only, not receive-full; idle irq when enabled
// - while full, holding buffer kept; shift register overwritten
// - idle flag bit 4, cleared by sequence, rearmed only after full
// - overrun flag bit 3 set when word completes while full; irqs
// - noise flag bit 2 set on noisy frame, no own irq; but IRQMSK bit 2 lets its event raise irq
// - framing flag bit 1 on desync, noise or break, no own irq; but IRQMSK bit 3 lets its event raise irq
// - framing plus overrun on one word reports overrun only
// - parity flag bit 0, irq when parity irq enabled, clears by sequence
module srx_uart (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             irq
);
    logic [7:0]  ctrl1_reg;
    logic [7:0]  ctrl2_reg;
    logic [15:0] baud_reg;
    logic [4:0]  irqMask_reg;
    logic [4:0]  irqStat_reg;
    logic [7:0]  rxHold_reg;
    logic        rxFull_reg;
    srx_pkg::srx_err_s err_reg;
    logic        idleArm_reg;
    logic        statSeen_reg;
    logic [7:0]  txHold_reg;
    logic        txEmpty_reg;
    logic        awHeld_reg;
    logic        wHeld_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;

    // baud tick at 16x oversampling
    logic [15:0] divCnt_reg;
    logic        tick;
    assign tick = (divCnt_reg == 16'h0000);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            divCnt_reg <= 16'h0000;
        end else if (tick) begin
            divCnt_reg <= baud_reg - 16'h0001;
        end else begin
            divCnt_reg <= divCnt_reg - 16'h0001;
        end
    end

    // bus handshake; each ready pulses once per offered item
    logic doRead;
    assign doRead = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h0000_0000;
            wStrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= srx_pkg::RESP_OK;
        end else begin
            s_axi_awready <= s_axi_awvalid && !awHeld_reg && !s_axi_awready
                             && !s_axi_bvalid;
            s_axi_wready  <= s_axi_wvalid && !wHeld_reg && !s_axi_wready
                             && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awAddr_reg)
                    srx_pkg::ADDR_DATA, srx_pkg::ADDR_CTRL1,
                    srx_pkg::ADDR_CTRL2, srx_pkg::ADDR_BAUD,
                    srx_pkg::ADDR_IRQMSK, srx_pkg::ADDR_STATUS,
                    srx_pkg::ADDR_IRQST: s_axi_bresp <= srx_pkg::RESP_OK;
                    default: s_axi_bresp <= srx_pkg::RESP_ERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic wrFire;
    assign wrFire = awHeld_reg && wHeld_reg && !s_axi_bvalid && wStrb_reg[0];

    // control registers
    logic [8:0] rxShift_reg;
    logic       rxCommit;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl1_reg   <= srx_pkg::CTRL_RST;
            ctrl2_reg   <= srx_pkg::CTRL_RST;
            baud_reg    <= srx_pkg::BAUD_RST;
            irqMask_reg <= 5'h00;
        end else begin
            if (wrFire && awAddr_reg == srx_pkg::ADDR_CTRL1)
                ctrl1_reg <= {ctrl1_reg[7], wData_reg[6:0]};
            else if (rxCommit && ctrl1_reg[srx_pkg::C1_WORD9])
                ctrl1_reg[srx_pkg::C1_NINTH] <= rxShift_reg[8];
            if (wrFire && awAddr_reg == srx_pkg::ADDR_CTRL2)
                ctrl2_reg <= wData_reg[7:0];
            if (wrFire && awAddr_reg == srx_pkg::ADDR_BAUD)
                baud_reg <= (wData_reg[15:0] == 16'h0000) ? 16'h0001
                                                          : wData_reg[15:0];
            if (wrFire && awAddr_reg == srx_pkg::ADDR_IRQMSK)
                irqMask_reg <= wData_reg[4:0];
        end
    end

    // receiver
    srx_pkg::srx_rx_e rxState_reg;
    logic [3:0] rxTick_reg;
    logic [3:0] rxBit_reg;
    logic [2:0] smp_reg;
    logic       rxNoise_reg;
    logic       rxPar_reg;
    logic [3:0] idleCnt_reg;
    logic       rxIdleEv;
    logic       frmErr;
    logic       parErr;
    logic       maj;
    logic       nbits;
    logic [3:0] wordBits;
    assign maj = (smp_reg[0] & smp_reg[1]) | (smp_reg[1] & rx_pin)
                 | (smp_reg[0] & rx_pin);
    assign nbits = !((smp_reg[0] == smp_reg[1]) && (smp_reg[1] == rx_pin));
    assign wordBits = (ctrl1_reg[srx_pkg::C1_WORD9] ? 4'd9 : 4'd8)
                      + {3'd0, ctrl1_reg[srx_pkg::C1_PAREN]};
    logic stopNow;
    assign stopNow = tick && rxState_reg == srx_pkg::RX_STOP
                     && rxTick_reg == 4'd9;
    assign frmErr = !maj;
    assign parErr = ctrl1_reg[srx_pkg::C1_PAREN]
                    && (rxPar_reg != ctrl1_reg[srx_pkg::C1_PARODD]);
    assign rxCommit = stopNow;
    assign rxIdleEv = tick && rxState_reg == srx_pkg::RX_IDLE
                      && idleCnt_reg == 4'd10 && idleArm_reg
                      && ctrl2_reg[srx_pkg::C2_RXEN];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxState_reg <= srx_pkg::RX_IDLE;
            rxTick_reg  <= 4'd0;
            rxBit_reg   <= 4'd0;
            rxShift_reg <= 9'h000;
            smp_reg     <= 3'b111;
            rxNoise_reg <= 1'b0;
            rxPar_reg   <= 1'b0;
            idleCnt_reg <= 4'd0;
        end else if (tick) begin
            smp_reg <= {smp_reg[1:0], rx_pin};
            case (rxState_reg)
                srx_pkg::RX_IDLE: begin
                    // idle counts whole bit times of mark
                    rxTick_reg <= rxTick_reg + 4'd1;
                    if (!ctrl2_reg[srx_pkg::C2_RXEN]) begin
                        idleCnt_reg <= 4'd0;
                    end else if (!rx_pin) begin
                        rxState_reg <= srx_pkg::RX_START;
                        rxTick_reg  <= 4'd0;
                        rxNoise_reg <= 1'b0;
                        rxPar_reg   <= 1'b0;
                        idleCnt_reg <= 4'd0;
                    end else if (rxTick_reg == 4'd15
                                 && idleCnt_reg != 4'd11) begin
                        idleCnt_reg <= idleCnt_reg + 4'd1;
                    end
                end
                srx_pkg::RX_START: begin
                    rxTick_reg <= rxTick_reg + 4'd1;
                    if (rxTick_reg == 4'd9) begin
                        rxNoise_reg <= nbits;
                        if (maj) begin
                            rxState_reg <= srx_pkg::RX_IDLE;
                        end else begin
                            rxState_reg <= srx_pkg::RX_DATA;
                            rxBit_reg   <= 4'd0;
                        end
                    end
                end
                srx_pkg::RX_DATA: begin
                    rxTick_reg <= rxTick_reg + 4'd1;
                    if (rxTick_reg == 4'd9) begin
                        rxNoise_reg <= rxNoise_reg | nbits;
                        rxPar_reg   <= rxPar_reg ^ maj;
                        if (rxBit_reg < (wordBits - 4'd1)
                            || !ctrl1_reg[srx_pkg::C1_PAREN]) begin
                            // lsb first into top of shift
                            rxShift_reg <= {maj, rxShift_reg[8:1]};
                        end
                        if (rxBit_reg == wordBits - 4'd1)
                            rxState_reg <= srx_pkg::RX_STOP;
                        rxBit_reg <= rxBit_reg + 4'd1;
                    end
                end
                srx_pkg::RX_STOP: begin
                    rxTick_reg <= rxTick_reg + 4'd1;
                    if (rxTick_reg == 4'd9) begin
                        rxState_reg <= srx_pkg::RX_IDLE;
                        if (!ctrl1_reg[srx_pkg::C1_WORD9])
                            rxShift_reg <= {1'b0, rxShift_reg[8:1]};
                    end
                end
                default: rxState_reg <= srx_pkg::RX_IDLE;
            endcase
        end
    end

    // receive flags; set beats the clear sequence
    logic clrSeq;
    assign clrSeq = doRead && s_axi_araddr == srx_pkg::ADDR_DATA
                    && statSeen_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxHold_reg   <= 8'h00;
            rxFull_reg   <= 1'b0;
            err_reg      <= '0;
            idleArm_reg  <= 1'b1;
            statSeen_reg <= 1'b0;
        end else begin
            if (doRead && s_axi_araddr == srx_pkg::ADDR_STATUS)
                statSeen_reg <= 1'b1;
            else if (clrSeq)
                statSeen_reg <= 1'b0;
            if (clrSeq) begin
                rxFull_reg <= 1'b0;
                err_reg    <= '0;
            end
            if (rxCommit) begin
                if (rxFull_reg && !clrSeq) begin
                    err_reg.overrun <= 1'b1;
                end else begin
                    rxHold_reg <= ctrl1_reg[srx_pkg::C1_WORD9]
                        ? rxShift_reg[7:0] : rxShift_reg[8:1];
                    rxFull_reg  <= 1'b1;
                    idleArm_reg <= 1'b1;
                    err_reg.framing <= frmErr;
                    err_reg.noise   <= rxNoise_reg | nbits;
                    err_reg.parity  <= parErr;
                    err_reg.overrun <= 1'b0;
                    err_reg.idle    <= 1'b0;
                end
            end else if (rxIdleEv) begin
                err_reg.idle <= 1'b1;
                idleArm_reg  <= 1'b0;
            end
        end
    end

    // transmitter
    srx_pkg::srx_tx_e txState_reg;
    logic [3:0]  txTick_reg;
    logic [3:0]  txBit_reg;
    logic [10:0] txShift_reg;
    logic        txEnPrev_reg;
    logic        breakPrev_reg;
    logic        idlePend_reg;
    logic        markPend_reg;
    logic        txToggle;
    assign txToggle = ctrl2_reg[srx_pkg::C2_TXEN] && !txEnPrev_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txState_reg   <= srx_pkg::TX_OFF;
            txTick_reg    <= 4'd0;
            txBit_reg     <= 4'd0;
            txShift_reg   <= 11'h7FF;
            txEnPrev_reg  <= 1'b0;
            breakPrev_reg <= 1'b0;
            idlePend_reg  <= 1'b0;
            markPend_reg  <= 1'b0;
            txHold_reg    <= 8'h00;
            txEmpty_reg   <= 1'b1;
            tx_pin        <= 1'b1;
        end else begin
            txEnPrev_reg  <= ctrl2_reg[srx_pkg::C2_TXEN];
            breakPrev_reg <= ctrl2_reg[srx_pkg::C2_BREAK];
            if (txToggle) begin
                idlePend_reg <= 1'b1;
                txEmpty_reg  <= 1'b1;
            end else if (wrFire && awAddr_reg == srx_pkg::ADDR_DATA) begin
                txHold_reg  <= wData_reg[7:0];
                txEmpty_reg <= 1'b0;
            end
            if (breakPrev_reg && !ctrl2_reg[srx_pkg::C2_BREAK])
                markPend_reg <= 1'b1;
            if (tick) begin
                txTick_reg <= txTick_reg + 4'd1;
                case (txState_reg)
                    srx_pkg::TX_OFF: begin
                        tx_pin <= !ctrl2_reg[srx_pkg::C2_BREAK];
                        txTick_reg <= 4'd0;
                        if (markPend_reg) begin
                            txState_reg  <= srx_pkg::TX_MARK;
                            markPend_reg <= 1'b0;
                        end else if (ctrl2_reg[srx_pkg::C2_TXEN]
                                     && idlePend_reg) begin
                            txState_reg  <= srx_pkg::TX_IDLEF;
                            idlePend_reg <= 1'b0;
                            txBit_reg    <= 4'd0;
                        end else if (ctrl2_reg[srx_pkg::C2_TXEN]
                                     && !txEmpty_reg && !txToggle) begin
                            txShift_reg <= {2'b11, txHold_reg, 1'b0};
                            txEmpty_reg <= 1'b1;
                            txBit_reg   <= 4'd0;
                            txState_reg <= srx_pkg::TX_FRAME;
                        end
                    end
                    srx_pkg::TX_IDLEF: begin
                        tx_pin <= 1'b1;
                        if (txTick_reg == 4'd15) begin
                            txBit_reg <= txBit_reg + 4'd1;
                            if (txBit_reg == 4'd9)
                                txState_reg <= srx_pkg::TX_OFF;
                        end
                    end
                    srx_pkg::TX_FRAME: begin
                        tx_pin <= txShift_reg[0];
                        if (txTick_reg == 4'd15) begin
                            txShift_reg <= {1'b1, txShift_reg[10:1]};
                            txBit_reg   <= txBit_reg + 4'd1;
                            if (txBit_reg == 4'd9)
                                txState_reg <= srx_pkg::TX_OFF;
                        end
                    end
                    srx_pkg::TX_MARK: begin
                        tx_pin <= 1'b1;
                        if (txTick_reg == 4'd15)
                            txState_reg <= srx_pkg::TX_OFF;
                    end
                    default: txState_reg <= srx_pkg::TX_OFF;
                endcase
            end
        end
    end

    // sticky event status, read clears; set wins
    srx_pkg::srx_err_s evt;
    logic rdIrqSt;
    assign evt.overrun = rxCommit && rxFull_reg && !clrSeq;
    assign evt.framing = rxCommit && !(rxFull_reg && !clrSeq) && frmErr;
    assign evt.noise   = rxCommit && !(rxFull_reg && !clrSeq)
                         && (rxNoise_reg | nbits);
    assign evt.parity  = rxCommit && !(rxFull_reg && !clrSeq) && parErr;
    assign evt.idle    = rxIdleEv;
    assign rdIrqSt = doRead && s_axi_araddr == srx_pkg::ADDR_IRQST;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqStat_reg <= 5'h00;
        end else begin
            irqStat_reg <= (rdIrqSt ? 5'h00 : irqStat_reg) | evt;
        end
    end

    // interrupt line
    logic gm;
    assign gm = ctrl2_reg[srx_pkg::C2_GMASK];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= (!gm && ctrl2_reg[srx_pkg::C2_RXIRQ]
                    && (rxFull_reg || err_reg.overrun))
                || (!gm && ctrl2_reg[srx_pkg::C2_IDLEIRQ]
                    && err_reg.idle)
                || (!gm && ctrl1_reg[srx_pkg::C1_PARIRQ]
                    && err_reg.parity)
                || |(irqStat_reg & irqMask_reg);
        end
    end

    // read channel
    logic [7:0] stat;
    assign stat = {txEmpty_reg, 1'b0, rxFull_reg, err_reg.idle,
                   err_reg.overrun, err_reg.noise, err_reg.framing,
                   err_reg.parity};
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= srx_pkg::RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= srx_pkg::RESP_OK;
                case (s_axi_araddr)
                    srx_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, stat};
                    srx_pkg::ADDR_DATA:   s_axi_rdata <= {24'h0, rxHold_reg};
                    srx_pkg::ADDR_CTRL1:  s_axi_rdata <= {24'h0, ctrl1_reg};
                    srx_pkg::ADDR_CTRL2:  s_axi_rdata <= {24'h0, ctrl2_reg};
                    srx_pkg::ADDR_BAUD:   s_axi_rdata <= {16'h0, baud_reg};
                    srx_pkg::ADDR_IRQST:  s_axi_rdata <= {27'h0, irqStat_reg};
                    srx_pkg::ADDR_IRQMSK: s_axi_rdata <= {27'h0, irqMask_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= srx_pkg::RESP_ERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/srx_uart_properties.sv */
`timescale 1ns/10ps
module srx_uart_properties (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        tx_pin,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no read answer");
    read_cause_a: assert property ($rose(s_axi_rvalid) |->
        $past(s_axi_arready)) else $error("read answer unasked");
    unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > srx_pkg::ADDR_IRQMSK |=> s_axi_rdata == 32'h0 &&
        s_axi_rresp == srx_pkg::RESP_ERR) else $error("unmapped read ok");
    upper_zero_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    one_resp_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("second write answer");
    reset_quiet_a: assert property ($rose(rstn) |-> tx_pin && !irq &&
        !s_axi_rvalid) else $error("outputs busy after reset");
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == srx_pkg::RESP_ERR);
endmodule
bind srx_uart srx_uart_properties chk (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .tx_pin(tx_pin), .irq(irq));

/* File: tb/srx_remote_tx.sv */
`timescale 1ns/10ps
module srx_remote_tx #(parameter int BIT = 16) (
    input wire logic clk_sys,
    output logic     rx_pin
);
    initial rx_pin = 1'b1;
    // line rests at mark between frames
    task automatic send(input logic [9:0] w, input int n, input logic sb);
        rx_pin <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            rx_pin <= w[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rx_pin <= sb;
        repeat (BIT) @(posedge clk_sys);
        rx_pin <= 1'b1;
        repeat (BIT) @(posedge clk_sys);
    endtask
endmodule

/* File: tb/srx_uart_tb_top.sv */
`timescale 1ns/10ps
`define CK(s, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", s, e, g); end end
module srx_uart_tb_top;
    logic        clk_sys, rstn, awv, wv, bry, arv, rry, awr, wr_, bv, arr, rv;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, d;
    logic [1:0]  bresp, rresp, r;
    logic        rxPin, txPin, irq;
    int          fails, checks_done, cyc, n;
    srx_uart uut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .rx_pin(rxPin), .tx_pin(txPin), .irq(irq));
    srx_remote_tx #(.BIT(16)) rem (.clk_sys(clk_sys), .rx_pin(rxPin));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {awa, wd, awv, wv, bry} <= {a, v, 3'b111};
        do begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        {ara, arv, rry} <= {a, 2'b11};
        do begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        {d, r} = {rdat, rresp};
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results;
        end
    end
    initial begin
        {rstn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        wr(srx_pkg::ADDR_BAUD, 32'h1);
        `CK("bresp", srx_pkg::RESP_OK, r)
        wr(srx_pkg::ADDR_IRQMSK, 32'h1F);
        wr(srx_pkg::ADDR_CTRL2, 32'h24);
        rem.send(10'h0A5, 8, 1'b1);
        repeat (4) @(posedge clk_sys);
        `CK("irq", 1'b1, irq)
        wr(srx_pkg::ADDR_CTRL2, 32'hA4);
        repeat (2) @(posedge clk_sys);
        `CK("masked irq", 1'b0, irq)
        wr(srx_pkg::ADDR_CTRL2, 32'h24);
        rd(srx_pkg::ADDR_STATUS);
        `CK("status", 6'h20, d[5:0])
        rd(srx_pkg::ADDR_DATA);
        `CK("data", 8'hA5, d[7:0])
        rd(srx_pkg::ADDR_STATUS);
        `CK("full", 1'b0, d[5])
        $display("receive test done");
        repeat (200) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        `CK("idle", 1'b1, d[4])
        rd(srx_pkg::ADDR_IRQST);
        `CK("idle event", 1'b1, d[0])
        rd(srx_pkg::ADDR_DATA);
        repeat (200) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        `CK("idle rearm", 1'b0, d[4])
        $display("idle test done");
        rem.send(10'h03C, 8, 1'b1);
        rem.send(10'h000, 8, 1'b0);
        repeat (4) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        `CK("overrun", 6'h28, d[5:0])
        rd(srx_pkg::ADDR_IRQST);
        `CK("overrun event", 1'b1, d[4])
        rd(srx_pkg::ADDR_IRQST);
        `CK("event cleared", 1'b0, d[4])
        rd(srx_pkg::ADDR_DATA);
        `CK("kept data", 8'h3C, d[7:0])
        rem.send(10'h000, 8, 1'b0);
        repeat (4) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        `CK("framing", 1'b1, d[1])
        rd(srx_pkg::ADDR_DATA);
        $display("error test done");
        wr(srx_pkg::ADDR_CTRL1, 32'h10);
        rem.send(10'h15A, 9, 1'b1);
        repeat (4) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        rd(srx_pkg::ADDR_CTRL1);
        `CK("ninth bit", 1'b1, d[7])
        rd(srx_pkg::ADDR_DATA);
        `CK("nine bit data", 8'h5A, d[7:0])
        wr(srx_pkg::ADDR_CTRL1, 32'h16);
        rem.send(10'h001, 10, 1'b1);
        repeat (4) @(posedge clk_sys);
        rd(srx_pkg::ADDR_STATUS);
        `CK("parity", 1'b1, d[0])
        rd(srx_pkg::ADDR_DATA);
        rd(8'h1C);
        `CK("unmapped", srx_pkg::RESP_ERR, r)
        $display("word test done");
        wr(srx_pkg::ADDR_CTRL1, 32'h0);
        wr(srx_pkg::ADDR_CTRL2, 32'h2C);
        wr(srx_pkg::ADDR_DATA, 32'h55);
        for (n = 0; txPin === 1'b1 && n < 400; n++) @(posedge clk_sys);
        `CK("idle frame first", 1'b1, n >= 150)
        repeat (24) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            d[i] = txPin;
            repeat (16) @(posedge clk_sys);
        end
        `CK("sent byte", 8'h55, d[7:0])
        $display("transmit test done");
        results;
    end
endmodule
